// ==== design/bdc_control.sv ====
// Behaviour
// - direct value for converter 2 at 84h, read/write, volatility per control bit.
// - select bit 7 feeds converter 2 from the direct value register.
// - select and full-scale register sits at 85h, read/write.
// - generator 1 full-scale code 00 external, then 0.4, 0.85, 1.3 mA.
// - generator 2 full-scale field uses the same four codes.
// - table 1 row comes from converter result, or row value when selected.
// - table 2 row comes from converter result, or row value when selected.
// - converter 1 takes table 1 row, or control register 3 when selected.
// - writes other than to 86h without write enable latch set are aborted and not acknowledged.
// - latch clears at power-up, 80h at 86h sets, 00h clears.
// - changing the latch leaves other bits of 86h untouched.
// - read-only status at 87h shows the result in its upper six bits.
// - result is plain binary, zero at minimum, all ones at full scale.
// - result moves after four equal conversions, or every one when bypassed.
// - reference select defaults to internal, one picks external reference.
// - converter input defaults to temperature sensor, one picks external sense.
// - row address is table base 90h or d0h plus six-bit row.
// - converter inputs stay 00h until a first valid result selects rows or a direct select bit is set.
// - nonvolatile control bits load into working registers on the same clock edge that outputs enable.
// - converter direct select wins over the table direct select.
`timescale 1ns/1ps
`default_nettype none

module bdc_control
    import bdc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [2:0] addr_pins,
    input wire logic [7:0] nv_dac2_image,
    input wire logic [7:0] nv_select_image,
    input wire logic control_volatility_select,
    input wire logic reference_select_bit,
    input wire logic input_select_bit,
    input wire logic result_filter_bypass,
    input wire logic [5:0] table1_row_value,
    input wire logic [5:0] table2_row_value,
    input wire logic [7:0] dac1_direct_value,
    input wire logic conv_valid,
    input wire logic [5:0] conv_code,
    input wire logic [7:0] table1_byte,
    input wire logic [7:0] table2_byte,
    output logic [7:0] table1_row_addr,
    output logic [7:0] table2_row_addr,
    output logic [7:0] dac1_input,
    output logic [7:0] dac2_input,
    output bdc_pkg::bdc_fullscale_t gen1_fullscale,
    output bdc_pkg::bdc_fullscale_t gen2_fullscale,
    output logic reference_source_select,
    output logic converter_input_select,
    output logic outputs_enable,
    output logic nv_write_strobe,
    output logic [7:0] nv_write_addr,
    output logic [7:0] nv_write_data
);

    typedef struct packed {
        logic [1:0] scl_sync;
        logic scl_last;
        logic [1:0] sda_sync;
        logic sda_last;
        logic [5:0] pin_sync;
        bdc_serial_state_t state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic is_read;
        logic ack_ok;
        logic sda_oe;
        logic sda_out;
        logic [7:0] dac2_direct_value;
        logic [7:0] select;
        logic write_enable_latch;
        logic loaded;
        logic [7:0] table1_row_addr;
        logic [7:0] table2_row_addr;
        logic [7:0] dac1_input;
        logic [7:0] dac2_input;
        logic reference_source_select;
        logic converter_input_select;
        logic nv_write_strobe;
        logic [7:0] nv_write_addr;
        logic [7:0] nv_write_data;
    } bdc_main_state_t;

    bdc_main_state_t s;
    bdc_main_state_t next_s;
    bdc_filter_if fi ();

    logic scl_rise;
    logic scl_fall;
    logic sda_now;
    logic start_cond;
    logic stop_cond;
    logic addr_match;
    logic [7:0] rd_byte;
    logic [7:0] rd_next;
    logic wr_now;
    logic wr_ok;
    logic [5:0] row1;
    logic [5:0] row2;

    function automatic logic [7:0] read_reg(
        input logic [7:0] addr,
        input logic [7:0] dac2_val,
        input logic [7:0] sel,
        input logic write_enable_latch,
        input logic [5:0] result
    );
        logic [7:0] value;
        value = 8'h00;
        case (addr)
            ADDR_DAC2_DIRECT: value = dac2_val;
            ADDR_SELECT: value = sel;
            ADDR_WRITE_ENABLE: value[WEL_POS] = write_enable_latch;
            ADDR_STATUS: value[RESULT_LSB +: 6] = result;
            default: value = 8'h00;
        endcase
        return value;
    endfunction : read_reg

    // the filter keeps its own history so a bypass flip takes effect at once
    assign fi.conv_valid = conv_valid;
    assign fi.conv_code = conv_code;
    assign fi.bypass = result_filter_bypass;

    bdc_result_filter u_filter (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .f(fi.filt)
    );

    // only the second sync stage and its delayed copy are looked at
    assign sda_now = s.sda_sync[1];
    assign scl_rise = s.scl_sync[1] && !s.scl_last;
    assign scl_fall = !s.scl_sync[1] && s.scl_last;
    assign start_cond = s.scl_sync[1] && s.scl_last && s.sda_last && !sda_now;
    assign stop_cond = s.scl_sync[1] && s.scl_last && !s.sda_last && sda_now;
    assign addr_match = s.shift[7:1] == {DEVICE_TYPE, s.pin_sync[5:3]};
    assign rd_byte = read_reg(s.ptr, s.dac2_direct_value, s.select, s.write_enable_latch,
                              fi.result);
    assign rd_next = read_reg(s.ptr + 8'h01, s.dac2_direct_value, s.select,
                              s.write_enable_latch, fi.result);

    assign row1 = s.select[SEL_TABLE1_DIRECT] ? table1_row_value : fi.result;
    assign row2 = s.select[SEL_TABLE2_DIRECT] ? table2_row_value : fi.result;

    always_comb begin
        next_s = s;
        wr_now = 1'b0;
        wr_ok = 1'b0;
        next_s.scl_sync = {s.scl_sync[0], scl_in};
        next_s.scl_last = s.scl_sync[1];
        next_s.sda_sync = {s.sda_sync[0], sda_in};
        next_s.sda_last = s.sda_sync[1];
        next_s.pin_sync = {s.pin_sync[2:0], addr_pins};
        next_s.nv_write_strobe = 1'b0;

        if (!s.loaded) begin
            next_s.dac2_direct_value = nv_dac2_image;
            next_s.select = nv_select_image;
            next_s.loaded = 1'b1;
        end

        if (start_cond) begin
            next_s.state = ST_ADDR;
            next_s.bit_cnt = 4'h0;
            next_s.sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_s.state = ST_IDLE;
            next_s.sda_oe = 1'b0;
        end else begin
            case (s.state)
                ST_ADDR, ST_WADDR, ST_WDATA: begin
                    if (scl_rise && s.bit_cnt != BITS_PER_BYTE) begin
                        next_s.shift = {s.shift[6:0], sda_now};
                        next_s.bit_cnt = s.bit_cnt + 4'h1;
                    end else if (scl_fall && s.bit_cnt == BITS_PER_BYTE) begin
                        next_s.bit_cnt = 4'h0;
                        case (s.state)
                            ST_ADDR: begin
                                next_s.ack_ok = addr_match;
                                next_s.is_read = s.shift[0];
                                next_s.state = ST_ACK_ADDR;
                            end
                            ST_WADDR: begin
                                next_s.ack_ok = 1'b1;
                                next_s.ptr = s.shift;
                                next_s.state = ST_ACK_WADDR;
                            end
                            default: begin
                                wr_now = 1'b1;
                                wr_ok = s.write_enable_latch || s.ptr == ADDR_WRITE_ENABLE;
                                next_s.ack_ok = wr_ok;
                                next_s.state = ST_ACK_WDATA;
                            end
                        endcase
                        next_s.sda_oe = next_s.ack_ok;
                    end
                end
                ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (!s.ack_ok) begin
                            next_s.state = ST_IDLE;
                            next_s.sda_oe = 1'b0;
                        end else if (s.is_read) begin
                            next_s.state = ST_RDATA;
                            next_s.shift = rd_byte;
                            next_s.sda_oe = !rd_byte[7];
                        end else begin
                            next_s.state = ST_WADDR;
                            next_s.sda_oe = 1'b0;
                        end
                    end
                end
                ST_ACK_WADDR: begin
                    if (scl_fall) begin
                        next_s.state = ST_WDATA;
                        next_s.sda_oe = 1'b0;
                    end
                end
                ST_ACK_WDATA: begin
                    if (scl_fall) begin
                        next_s.sda_oe = 1'b0;
                        next_s.state = s.ack_ok ? ST_WDATA : ST_IDLE;
                        if (s.ack_ok) begin
                            next_s.ptr = s.ptr + 8'h01;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        next_s.bit_cnt = s.bit_cnt + 4'h1;
                    end else if (scl_fall && s.bit_cnt == BITS_PER_BYTE) begin
                        next_s.bit_cnt = 4'h0;
                        next_s.sda_oe = 1'b0;
                        next_s.state = ST_RACK;
                    end else if (scl_fall) begin
                        next_s.shift = {s.shift[6:0], 1'b0};
                        next_s.sda_oe = !s.shift[6];
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        next_s.ack_ok = !sda_now;
                    end else if (scl_fall && s.ack_ok) begin
                        next_s.ptr = s.ptr + 8'h01;
                        next_s.shift = rd_next;
                        next_s.sda_oe = !rd_next[7];
                        next_s.state = ST_RDATA;
                    end else if (scl_fall) begin
                        next_s.state = ST_IDLE;
                    end
                end
                default: begin
                    next_s.sda_oe = 1'b0;
                end
            endcase
        end

        if (wr_now && wr_ok) begin
            case (s.ptr)
                ADDR_DAC2_DIRECT: begin
                    next_s.dac2_direct_value = s.shift;
                    next_s.nv_write_strobe = control_volatility_select;
                end
                ADDR_SELECT: begin
                    next_s.select = s.shift;
                    next_s.nv_write_strobe = 1'b1;
                end
                ADDR_WRITE_ENABLE: begin
                    if (s.shift == WEL_SET_CODE) begin
                        next_s.write_enable_latch = 1'b1;
                    end else if (s.shift == WEL_CLEAR_CODE) begin
                        next_s.write_enable_latch = 1'b0;
                    end
                end
                default: begin
                    next_s.write_enable_latch = s.write_enable_latch;
                end
            endcase
            next_s.nv_write_addr = s.ptr;
            next_s.nv_write_data = s.shift;
        end

        next_s.table1_row_addr = TABLE1_BASE + {2'b00, row1};
        next_s.table2_row_addr = TABLE2_BASE + {2'b00, row2};

        if (!s.loaded) begin
            next_s.dac1_input = DAC_IDLE;
        end else if (s.select[SEL_DAC1_DIRECT]) begin
            next_s.dac1_input = dac1_direct_value;
        end else if (s.select[SEL_TABLE1_DIRECT] || fi.result_seen) begin
            next_s.dac1_input = table1_byte;
        end else begin
            next_s.dac1_input = DAC_IDLE;
        end

        if (!s.loaded) begin
            next_s.dac2_input = DAC_IDLE;
        end else if (s.select[SEL_DAC2_DIRECT]) begin
            next_s.dac2_input = s.dac2_direct_value;
        end else if (s.select[SEL_TABLE2_DIRECT] || fi.result_seen) begin
            next_s.dac2_input = table2_byte;
        end else begin
            next_s.dac2_input = DAC_IDLE;
        end

        next_s.reference_source_select = reference_select_bit;
        next_s.converter_input_select = input_select_bit;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
            s.select <= SELECT_RESET;
            s.dac2_direct_value <= DAC2_DIRECT_RESET;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // open drain: only ever pulls low
    assign sda_out = s.sda_out;
    assign sda_oe = s.sda_oe;
    assign table1_row_addr = s.table1_row_addr;
    assign table2_row_addr = s.table2_row_addr;
    assign dac1_input = s.dac1_input;
    assign dac2_input = s.dac2_input;
    assign gen1_fullscale = bdc_fullscale_t'(s.select[GEN1_FS_LSB +: 2]);
    assign gen2_fullscale = bdc_fullscale_t'(s.select[GEN2_FS_LSB +: 2]);
    assign reference_source_select = s.reference_source_select;
    assign converter_input_select = s.converter_input_select;
    assign outputs_enable = s.loaded;
    assign nv_write_strobe = s.nv_write_strobe;
    assign nv_write_addr = s.nv_write_addr;
    assign nv_write_data = s.nv_write_data;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence start_seq;
        ce && start_cond;
    endsequence

    sequence data_end_seq;
        ce && wr_now && !start_cond && !stop_cond;
    endsequence

    start_to_addr_a: assert property (
        start_seq |=> s.state == ST_ADDR && !s.sda_oe)
        else $error("start did not open an address byte");

    dac2_store_a: assert property (
        data_end_seq ##0 (s.write_enable_latch && s.ptr == ADDR_DAC2_DIRECT)
        |=> s.dac2_direct_value == $past(s.shift))
        else $error("direct value not stored");

    write_guard_a: assert property (
        data_end_seq ##0 (!s.write_enable_latch && s.ptr != ADDR_WRITE_ENABLE)
        |=> !s.sda_oe && $stable(s.select) && $stable(s.dac2_direct_value))
        else $error("write taken without latch");

    wel_set_a: assert property (
        data_end_seq ##0 (s.ptr == ADDR_WRITE_ENABLE && s.shift == WEL_SET_CODE)
        |=> s.write_enable_latch ##1 s.sda_oe || !ce)
        else $error("latch not set by 80h");

    wel_clear_a: assert property (
        data_end_seq ##0 (s.ptr == ADDR_WRITE_ENABLE && s.shift == WEL_CLEAR_CODE)
        |=> !s.write_enable_latch)
        else $error("latch not cleared by 00h");

    dac2_direct_a: assert property (
        ce && s.loaded && s.select[SEL_DAC2_DIRECT]
        |=> dac2_input == $past(s.dac2_direct_value))
        else $error("converter 2 not fed from direct value");

    row_addr_a: assert property (
        ce && !s.select[SEL_TABLE1_DIRECT]
        |=> table1_row_addr == TABLE1_BASE + {2'b00, $past(fi.result)})
        else $error("table 1 row address wrong");

    dac_idle_a: assert property (
        ce && !fi.result_seen && !s.select[SEL_DAC1_DIRECT]
        && !s.select[SEL_TABLE1_DIRECT] |=> dac1_input == DAC_IDLE)
        else $error("converter 1 left idle value early");

endmodule : bdc_control

`default_nettype wire

// ==== design/bdc_filter_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface bdc_filter_if;
    logic conv_valid;
    logic [5:0] conv_code;
    logic bypass;
    logic [5:0] result;
    logic result_seen;

    modport filt (
        input conv_valid,
        input conv_code,
        input bypass,
        output result,
        output result_seen
    );

    modport ctl (
        output conv_valid,
        output conv_code,
        output bypass,
        input result,
        input result_seen
    );
endinterface : bdc_filter_if

`default_nettype wire

// ==== design/bdc_pkg.sv ====
package bdc_pkg;

    // byte addresses of the registers kept by this block
    localparam logic [7:0] ADDR_DAC2_DIRECT = 8'h84;
    localparam logic [7:0] ADDR_SELECT = 8'h85;
    localparam logic [7:0] ADDR_WRITE_ENABLE = 8'h86;
    localparam logic [7:0] ADDR_STATUS = 8'h87;

    // lookup table bases, 64 rows each
    localparam logic [7:0] TABLE1_BASE = 8'h90;
    localparam logic [7:0] TABLE2_BASE = 8'hd0;

    // write enable latch codes and position
    localparam logic [7:0] WEL_SET_CODE = 8'h80;
    localparam logic [7:0] WEL_CLEAR_CODE = 8'h00;
    localparam int WEL_POS = 7;

    // select register field positions
    localparam int SEL_DAC2_DIRECT = 7;
    localparam int SEL_TABLE2_DIRECT = 6;
    localparam int SEL_DAC1_DIRECT = 5;
    localparam int SEL_TABLE1_DIRECT = 4;
    localparam int GEN2_FS_LSB = 2;
    localparam int GEN1_FS_LSB = 0;

    // status register: result in the six upper bits
    localparam int RESULT_LSB = 2;

    // reset values
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [7:0] DAC2_DIRECT_RESET = 8'h00;
    localparam logic [7:0] DAC_IDLE = 8'h00;

    // serial framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // upper four bits of the slave address; value is arbitrary
    localparam logic [3:0] DEVICE_TYPE = 4'h5;

    // conversions that must agree before the result moves
    localparam int FILTER_RUN = 4;
    localparam logic [1:0] FILTER_LAST_MATCH = 2'(FILTER_RUN - 1);

    typedef enum logic [1:0] {
        FS_EXTERNAL,
        FS_LOW_0P4MA,
        FS_MID_0P85MA,
        FS_HIGH_1P3MA
    } bdc_fullscale_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_WADDR,
        ST_ACK_WADDR,
        ST_WDATA,
        ST_ACK_WDATA,
        ST_RDATA,
        ST_RACK
    } bdc_serial_state_t;

endpackage : bdc_pkg

// ==== design/bdc_result_filter.sv ====
`timescale 1ns/1ps
`default_nettype none

module bdc_result_filter
    import bdc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    bdc_filter_if.filt f
);

    typedef struct packed {
        logic primed;
        logic [5:0] last;
        logic [1:0] run;
        logic [5:0] result;
        logic seen;
    } bdc_filter_state_t;

    bdc_filter_state_t s;
    bdc_filter_state_t next_s;
    logic same;

    assign same = s.primed && (f.conv_code == s.last);

    always_comb begin
        next_s = s;
        if (f.conv_valid) begin
            next_s.primed = 1'b1;
            next_s.last = f.conv_code;
            if (!same) begin
                next_s.run = 2'h0;
            end else if (s.run != FILTER_LAST_MATCH) begin
                next_s.run = s.run + 2'h1;
            end
            if (f.bypass || next_s.run == FILTER_LAST_MATCH) begin
                next_s.result = f.conv_code;
                next_s.seen = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign f.result = s.result;
    assign f.result_seen = s.seen;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    filt_bypass_a: assert property (
        ce && f.conv_valid && f.bypass |=> f.result == $past(f.conv_code))
        else $error("bypassed result not taken");

    filt_hold_a: assert property (
        ce && f.conv_valid && !f.bypass && !(same && s.run >= 2'h2)
        |=> $stable(f.result))
        else $error("result moved before four equal codes");

endmodule : bdc_result_filter

`default_nettype wire

// ==== test/bdc_bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none

module bdc_bus_master (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // idle bus: clock parked high, data left to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic frame_start();
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask : frame_start

    task automatic frame_stop();
        tick(1);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
    endtask : frame_stop

    // low phase is the longer one so a late slave release settles first
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            tick(1);
            sda_low = ~tx[i];
            tick(4);
            scl = 1'b1;
            tick(3);
            rx[i] = sda;
            scl = 1'b0;
        end
    endtask : xfer
endmodule : bdc_bus_master

`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import bdc_pkg::*;
    logic clk = 1'b0, reset = 1'b1, conv_valid = 1'b0;
    logic result_filter_bypass = 1'b0;
    logic scl, sda_low, sda_out, sda_oe, outputs_enable, nv_write_strobe;
    logic reference_select_bit, input_select_bit;
    logic reference_source_select, converter_input_select;
    logic [2:0] addr_pins;
    logic [5:0] table1_row_value, table2_row_value, conv_code;
    logic [7:0] nv_select_image, table1_byte, table2_byte, dac1_direct_value;
    logic [7:0] table1_row_addr, table2_row_addr, dac1_input, dac2_input;
    logic [7:0] nv_write_addr, nv_write_data, v, got;
    logic [31:0] seed = 32'd98960;
    bdc_fullscale_t gen1_fullscale, gen2_fullscale;
    int n_mismatch = 0, n_compared = 0;
    wire logic sda;

    always #25 clk = ~clk;
    // open drain: either party pulling wins, else the pull-up
    assign sda = ~(sda_oe | sda_low);

    bdc_bus_master i_bdc_bus_master (.clk, .sda, .scl, .sda_low);
    bdc_control i_bdc_control (
        .clk, .reset, .ce(1'b1), .scl_in(scl), .sda_in(sda), .sda_out,
        .sda_oe, .addr_pins, .nv_dac2_image(8'h00), .nv_select_image,
        .control_volatility_select(1'b0), .reference_select_bit,
        .input_select_bit, .result_filter_bypass, .table1_row_value,
        .table2_row_value, .dac1_direct_value, .conv_valid, .conv_code,
        .table1_byte, .table2_byte, .table1_row_addr, .table2_row_addr,
        .dac1_input, .dac2_input, .gen1_fullscale, .gen2_fullscale,
        .reference_source_select, .converter_input_select, .outputs_enable,
        .nv_write_strobe, .nv_write_addr, .nv_write_data
    );

    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd

    function automatic logic [7:0] row_exp(logic [7:0] b, logic [5:0] r);
        return b + {2'b00, r};
    endfunction : row_exp

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [7:0] d, logic ack);
        logic [8:0] rx;
        i_bdc_bus_master.frame_start();
        i_bdc_bus_master.xfer({DEVICE_TYPE, addr_pins, 2'b01}, rx);
        i_bdc_bus_master.xfer({a, 1'b1}, rx);
        i_bdc_bus_master.xfer({d, 1'b1}, rx);
        chk("data ack", {7'h00, ack}, {7'h00, ~rx[0]});
        i_bdc_bus_master.frame_stop();
    endtask : wr

    // single byte read ends with a master nack, so the pointer stays put
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        logic [8:0] rx;
        i_bdc_bus_master.frame_start();
        i_bdc_bus_master.xfer({DEVICE_TYPE, addr_pins, 2'b01}, rx);
        i_bdc_bus_master.xfer({a, 1'b1}, rx);
        i_bdc_bus_master.frame_stop();
        i_bdc_bus_master.frame_start();
        i_bdc_bus_master.xfer({DEVICE_TYPE, addr_pins, 2'b11}, rx);
        i_bdc_bus_master.xfer(9'h1ff, rx);
        d = rx[8:1];
        i_bdc_bus_master.frame_stop();
    endtask : rd

    task automatic pulse();
        @(posedge clk);
        #2 conv_valid = 1'b1;
        @(posedge clk);
        #2 conv_valid = 1'b0;
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic status_is(logic [5:0] c);
        rd(ADDR_STATUS, got);
        chk("status", {c, 2'b00}, got);
    endtask : status_is

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        nv_select_image = rnd() & 8'h0f;
        table1_byte = rnd();
        table2_byte = rnd();
        dac1_direct_value = rnd();
        table1_row_value = 6'(rnd());
        table2_row_value = 6'(rnd());
        conv_code = 6'(rnd());
        addr_pins = 3'(rnd());
        reference_select_bit = 1'b1;
        input_select_bit = 1'b0;
        repeat (2) @(posedge clk);
        #2 reset = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        chk("enable", 8'h01, {7'h00, outputs_enable});
        chk("gen1 fs", nv_select_image & 8'h03, 8'(gen1_fullscale));
        chk("gen2 fs", nv_select_image >> 2, 8'(gen2_fullscale));
        chk("ref", 8'h01, {7'h00, reference_source_select});
        chk("input", 8'h00, {7'h00, converter_input_select});
        chk("dac1 idle", 8'h00, dac1_input);
        wr(ADDR_SELECT, 8'h80, 1'b0);
        wr(ADDR_WRITE_ENABLE, WEL_SET_CODE, 1'b1);
        wr(ADDR_WRITE_ENABLE, 8'h7f, 1'b1);
        rd(ADDR_WRITE_ENABLE, got);
        chk("latch", 8'h80, got);
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_SELECT, {4'h0, 2'(c), 2'(c)}, 1'b1);
            chk("gen1 code", 8'(c), 8'(gen1_fullscale));
            chk("gen2 code", 8'(c), 8'(gen2_fullscale));
            chk("nv data", {4'h0, 2'(c), 2'(c)}, nv_write_data);
            chk("nv addr", ADDR_SELECT, nv_write_addr);
        end
        v = rnd();
        wr(ADDR_DAC2_DIRECT, v, 1'b1);
        wr(ADDR_SELECT, 8'h80, 1'b1);
        chk("dac2 direct", v, dac2_input);
        rd(ADDR_DAC2_DIRECT, got);
        chk("reg dac2", v, got);
        rd(ADDR_SELECT, got);
        chk("reg select", 8'h80, got);
        repeat (3) pulse();
        status_is(6'h00);
        pulse();
        status_is(conv_code);
        wr(ADDR_STATUS, 8'hff, 1'b1);
        status_is(conv_code);
        chk("row1", row_exp(TABLE1_BASE, conv_code), table1_row_addr);
        chk("dac1 table", table1_byte, dac1_input);
        result_filter_bypass = 1'b1;
        for (int k = 0; k < 2; k++) begin
            conv_code = k == 0 ? 6'h3f : 6'h00;
            pulse();
            status_is(conv_code);
        end
        wr(ADDR_SELECT, 8'h50, 1'b1);
        chk("row1 d", row_exp(TABLE1_BASE, table1_row_value), table1_row_addr);
        chk("row2 d", row_exp(TABLE2_BASE, table2_row_value), table2_row_addr);
        chk("dac2 table", table2_byte, dac2_input);
        wr(ADDR_SELECT, 8'h30, 1'b1);
        chk("dac1 direct", dac1_direct_value, dac1_input);
        wrap_up();
    end
endmodule : tb_top

`default_nettype wire
